// ==== design/scr_pend_bit.sv ====
module scr_pend_bit
    import scr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic set_req,
    input  wire logic msg_req,
    input  wire logic clr_wr,
    input  wire logic auto_off,
    output logic      pend_q
);
    logic msg_req_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            msg_req_q <= 1'b0;
        end else begin
            msg_req_q <= msg_req;
        end
    end

    // Set wins so a new request in the clearing cycle is kept
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pend_q <= 1'b0;
        end else if (set_req) begin
            pend_q <= 1'b1;
        end else if (clr_wr) begin
            pend_q <= 1'b0;
        end else if (!auto_off && msg_req_q && !msg_req) begin
            pend_q <= 1'b0;
        end
    end
endmodule // scr_pend_bit

// ==== design/scr_pkg.sv ====
package scr_pkg;
    localparam logic [15:0] STAT_COUNTER_2_OFS  = 16'h5b28;
    localparam logic [15:0] STAT_COUNTER_3_OFS  = 16'h5b2c;
    localparam logic [15:0] SOFTWARE_SEMA_OFS   = 16'h5b50;
    localparam logic [15:0] HOST_IF_CTRL_2_OFS  = 16'h5b64;
    localparam logic [15:0] PEND_CLEAR_OFS      = 16'h5b68;
    localparam logic [15:0] AUTOCLEAR_CTL_OFS   = 16'h5b6c;
    localparam int          DRIVER_SEMA_POS     = 0;
    localparam int          STORAGE_SEMA_POS    = 1;
    localparam int          INIT_DONE_POS       = 0;
    localparam int          AUTOCLEAR_POS       = 20;
    localparam int          PEND_WIDTH          = 5;
    localparam logic        DRIVER_SEMA_RST     = 1'b1;
    localparam logic        STORAGE_SEMA_RST    = 1'b0;
    localparam logic        INIT_DONE_RST       = 1'b0;
    localparam logic        AUTOCLEAR_RST       = 1'b0;
    localparam logic [31:0] COUNTER_RST         = 32'h0000_0000;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } scr_req_t;
endpackage

// ==== design/scr_regs.sv ====
// Notes on behaviour
// - Reading semaphore register sets driver flag
// - Driver flag clears only on written zero
// - First read after a written zero returns zero, later ones one
// - Only host sets storage flag; firmware reads
// - Soft reset clears storage flag
// - Write one clears matching pending bit
// - Autoclear on: request deassert clears pending
module scr_regs
    import scr_pkg::*;
#(
    parameter int NPEND = PEND_WIDTH
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             soft_rst,
    input  wire logic [15:0]      addr,
    input  wire logic [31:0]      wdata,
    input  wire logic             wr,
    input  wire logic             rd,
    input  wire logic [NPEND-1:0] pend_set,
    input  wire logic [NPEND-1:0] msg_req,
    output logic [31:0]           rdata,
    output logic [NPEND-1:0]      pend_bits,
    output logic                  storage_sema_fw,
    output logic                  init_done
);
    scr_req_t          req;
    logic              driver_sema_q;
    logic              storage_sema_q;
    logic              init_done_q;
    logic              autoclear_q;
    logic [31:0]       cnt2_q;
    logic [31:0]       cnt3_q;
    logic [31:0]       rdata_d;
    logic [NPEND-1:0]  pend_q;
    logic [NPEND-1:0]  clr_w;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // Read sets the flag while the word returned shows the old value
    // Flag leaves reset set, so software must clear it before first use
    always_ff @(posedge clk) begin
        if (!rstn) begin
            driver_sema_q <= DRIVER_SEMA_RST;
        end else if (req.wr && req.addr == SOFTWARE_SEMA_OFS) begin
            if (!req.wdata[DRIVER_SEMA_POS]) begin
                driver_sema_q <= 1'b0;
            end
        end else if (req.rd && req.addr == SOFTWARE_SEMA_OFS) begin
            driver_sema_q <= 1'b1;
        end
    end

    // Firmware sees this only through a read-only output
    always_ff @(posedge clk) begin
        if (!rstn || soft_rst) begin
            storage_sema_q <= STORAGE_SEMA_RST;
        end else if (req.wr && req.addr == SOFTWARE_SEMA_OFS) begin
            storage_sema_q <= req.wdata[STORAGE_SEMA_POS];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            init_done_q <= INIT_DONE_RST;
            autoclear_q <= AUTOCLEAR_RST;
        end else if (req.wr) begin
            if (req.addr == HOST_IF_CTRL_2_OFS) begin
                init_done_q <= req.wdata[INIT_DONE_POS];
            end else if (req.addr == AUTOCLEAR_CTL_OFS) begin
                autoclear_q <= req.wdata[AUTOCLEAR_POS];
            end
        end
    end

    // Counters have no documented events; plain storage only
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt2_q <= COUNTER_RST;
            cnt3_q <= COUNTER_RST;
        end else if (req.wr) begin
            if (req.addr == STAT_COUNTER_2_OFS) begin
                cnt2_q <= req.wdata;
            end else if (req.addr == STAT_COUNTER_3_OFS) begin
                cnt3_q <= req.wdata;
            end
        end
    end

    assign clr_w = (req.wr && req.addr == PEND_CLEAR_OFS)
                 ? req.wdata[NPEND-1:0] : '0;

    genvar g;
    generate
        for (g = 0; g < NPEND; g++) begin : g_pend
            scr_pend_bit u_pend (
                .clk      (clk),
                .rstn     (rstn),
                .set_req  (pend_set[g]),
                .msg_req  (msg_req[g]),
                .clr_wr   (clr_w[g]),
                .auto_off (autoclear_q),
                .pend_q   (pend_q[g])
            );
        end
    endgenerate

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (!req.rd) begin
            rdata_d = 32'h0000_0000;
        end else if (req.addr == SOFTWARE_SEMA_OFS) begin
            rdata_d[DRIVER_SEMA_POS]  = driver_sema_q;
            rdata_d[STORAGE_SEMA_POS] = storage_sema_q;
        end else if (req.addr == HOST_IF_CTRL_2_OFS) begin
            rdata_d[INIT_DONE_POS] = init_done_q;
        end else if (req.addr == AUTOCLEAR_CTL_OFS) begin
            rdata_d[AUTOCLEAR_POS] = autoclear_q;
        end else if (req.addr == STAT_COUNTER_2_OFS) begin
            rdata_d = cnt2_q;
        end else if (req.addr == STAT_COUNTER_3_OFS) begin
            rdata_d = cnt3_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata           <= 32'h0000_0000;
            pend_bits       <= '0;
            storage_sema_fw <= 1'b0;
            init_done       <= 1'b0;
        end else begin
            rdata           <= rdata_d;
            pend_bits       <= pend_q;
            storage_sema_fw <= storage_sema_q;
            init_done       <= init_done_q;
        end
    end

    chk_sema_read_sets: assert property (@(posedge clk) disable iff (!rstn)
        rd && addr == SOFTWARE_SEMA_OFS && !soft_rst |=> driver_sema_q)
        else $error("semaphore not set by read");
    chk_sema_zero_clears: assert property (@(posedge clk) disable iff (!rstn)
        wr && addr == SOFTWARE_SEMA_OFS && !wdata[0] |=> !driver_sema_q)
        else $error("semaphore not cleared by zero");
    chk_sema_holds: assert property (@(posedge clk) disable iff (!rstn)
        driver_sema_q && !(wr && addr == SOFTWARE_SEMA_OFS) |=> driver_sema_q)
        else $error("semaphore dropped without write");
    chk_sema_first_read: assert property (@(posedge clk) disable iff (!rstn)
        rd && addr == SOFTWARE_SEMA_OFS ##1 rd && addr == SOFTWARE_SEMA_OFS
        |=> rdata[0])
        else $error("second read did not return one");
    chk_sema_old_value: assert property (@(posedge clk) disable iff (!rstn)
        rd && addr == SOFTWARE_SEMA_OFS |=> rdata[0] == $past(driver_sema_q))
        else $error("read value not prior flag");
    chk_soft_rst_clr: assert property (@(posedge clk) disable iff (!rstn)
        soft_rst |=> !storage_sema_q ##1 !storage_sema_fw)
        else $error("storage flag survived soft reset");
    chk_pend_w1c: assert property (@(posedge clk) disable iff (!rstn)
        wr && addr == PEND_CLEAR_OFS && !pend_set[0] && wdata[0]
        |=> !pend_q[0])
        else $error("pending bit not cleared");
    chk_pend_zero_keep: assert property (@(posedge clk) disable iff (!rstn)
        wr && addr == PEND_CLEAR_OFS && !wdata[0] && pend_q[0]
        && autoclear_q |=> pend_q[0])
        else $error("pending bit cleared by zero");
    chk_pend_auto: assert property (@(posedge clk) disable iff (!rstn)
        !autoclear_q && $fell(msg_req[0]) && !pend_set[0] |=> !pend_q[0])
        else $error("pending not auto cleared");
    chk_rsvd_zero: assert property (@(posedge clk) disable iff (!rstn)
        rd && (addr == SOFTWARE_SEMA_OFS || addr == HOST_IF_CTRL_2_OFS)
        |=> rdata[31:2] == 30'h0)
        else $error("reserved bits nonzero");

    // Registered copies trail their source by exactly one edge
    chk_fw_copy: assert property (@(posedge clk) disable iff (!rstn)
        storage_sema_fw == $past(storage_sema_q))
        else $error("firmware copy of storage flag wrong");
    chk_storage_write: assert property (@(posedge clk) disable iff (!rstn)
        wr && addr == SOFTWARE_SEMA_OFS && !soft_rst
        |=> storage_sema_q == $past(wdata[STORAGE_SEMA_POS]))
        else $error("storage flag not written");
    chk_init_copy: assert property (@(posedge clk) disable iff (!rstn)
        wr && addr == HOST_IF_CTRL_2_OFS
        |=> ##1 init_done == $past(wdata[INIT_DONE_POS], 2))
        else $error("init bit not stored");
    chk_pend_copy: assert property (@(posedge clk) disable iff (!rstn)
        pend_bits == $past(pend_q))
        else $error("pending copy wrong");
    chk_pend_set_wins: assert property (@(posedge clk) disable iff (!rstn)
        pend_set[0] |=> pend_q[0])
        else $error("pending set lost");
    chk_pend_no_auto: assert property (@(posedge clk) disable iff (!rstn)
        autoclear_q && pend_q[0] && !clr_w[0] |=> pend_q[0])
        else $error("pending cleared with autoclear off");
    chk_clear_port_read: assert property (@(posedge clk) disable iff (!rstn)
        rd && addr == PEND_CLEAR_OFS |=> rdata == 32'h0000_0000)
        else $error("clear port read not zero");
    chk_rdata_idle: assert property (@(posedge clk) disable iff (!rstn)
        !rd |=> rdata == 32'h0000_0000)
        else $error("read data not zero when idle");
    chk_counter_store: assert property (@(posedge clk) disable iff (!rstn)
        wr && addr == STAT_COUNTER_2_OFS |=> cnt2_q == $past(wdata))
        else $error("counter word not stored");

    cov_sema_take: cover property (@(posedge clk) disable iff (!rstn)
        rd && addr == SOFTWARE_SEMA_OFS ##1 rd && addr == SOFTWARE_SEMA_OFS);
    cov_sema_free: cover property (@(posedge clk) disable iff (!rstn)
        driver_sema_q ##1 !driver_sema_q);
    cov_pend_clear: cover property (@(posedge clk) disable iff (!rstn)
        pend_q[0] ##1 !pend_q[0]);
    cov_soft_rst: cover property (@(posedge clk) disable iff (!rstn)
        storage_sema_q ##1 soft_rst);
    cov_pend_auto: cover property (@(posedge clk) disable iff (!rstn)
        !autoclear_q && pend_q[0] ##1 !pend_q[0]);
endmodule // scr_regs

// ==== verification/tb_top.sv ====
module tb_top
    import scr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk      = 1'b0;
    logic        rstn     = 1'b0;
    logic        soft_rst = 1'b0;
    logic        wr       = 1'b0;
    logic        rd       = 1'b0;
    logic [15:0] addr     = 16'h0000;
    logic [31:0] wdata    = 32'h0000_0000;
    logic [4:0]  pend_set = 5'h00;
    logic [4:0]  msg_req  = 5'h00;
    logic [31:0] rdata;
    logic [31:0] v;
    logic [31:0] d;
    logic [4:0]  pend_bits;
    logic [4:0]  s;
    logic [4:0]  m;
    logic [4:0]  r;
    logic        storage_sema_fw;
    logic        init_done;
    logic [15:0] ofs [6] = '{STAT_COUNTER_2_OFS, STAT_COUNTER_3_OFS,
        HOST_IF_CTRL_2_OFS, AUTOCLEAR_CTL_OFS, PEND_CLEAR_OFS, 16'h5b30};
    int          errors   = 0;
    int          n_tests  = 0;
    integer      seed     = 32'hfa111d9b;
    always #10 clk = ~clk;
    scr_regs #(.NPEND(PEND_WIDTH)) dut (.clk(clk), .rstn(rstn),
        .soft_rst(soft_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .pend_set(pend_set), .msg_req(msg_req), .rdata(rdata),
        .pend_bits(pend_bits), .storage_sema_fw(storage_sema_fw),
        .init_done(init_done));
    function automatic logic [31:0] exp_reg(logic [15:0] a, logic [31:0] x);
        if (a == STAT_COUNTER_2_OFS || a == STAT_COUNTER_3_OFS) return x;
        if (a == HOST_IF_CTRL_2_OFS) return {31'h0, x[INIT_DONE_POS]};
        if (a == AUTOCLEAR_CTL_OFS) return x & 32'h0010_0000;
        return 32'h0000_0000;
    endfunction
    function automatic logic [4:0] exp_pend(logic [4:0] a, logic [4:0] b);
        return a & ~b;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [31:0] x);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= x;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [31:0] x);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1 x = rdata;
    endtask
    // Registered copies trail the write by one more edge
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        foreach (ofs[i]) begin
            rd_reg(ofs[i], v);
            chk(v, 32'h0000_0000);
            d = $random(seed);
            wr_reg(ofs[i], d);
            rd_reg(ofs[i], v);
            chk(v, exp_reg(ofs[i], d));
        end
        wr_reg(HOST_IF_CTRL_2_OFS, 32'hffff_ffff);
        settle();
        chk({31'h0, init_done}, 32'h1);
        $display("Test register access done");
        rd_reg(SOFTWARE_SEMA_OFS, v);
        chk(v, {31'h0, DRIVER_SEMA_RST});
        wr_reg(SOFTWARE_SEMA_OFS, 32'h0000_0000);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= SOFTWARE_SEMA_OFS;
        @(posedge clk);
        #1 v = rdata;
        chk(v, 32'h0);
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
        chk(v, 32'h1);
        wr_reg(SOFTWARE_SEMA_OFS, 32'hffff_fffd);
        rd_reg(SOFTWARE_SEMA_OFS, v);
        chk(v, 32'h1);
        wr_reg(SOFTWARE_SEMA_OFS, 32'h0000_0002);
        settle();
        chk({31'h0, storage_sema_fw}, 32'h1);
        rd_reg(SOFTWARE_SEMA_OFS, v);
        chk(v, 32'h2);
        @(posedge clk);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        rd_reg(SOFTWARE_SEMA_OFS, v);
        chk(v, 32'h1);
        settle();
        chk({31'h0, storage_sema_fw}, 32'h0);
        $display("Test semaphore done");
        // Mode 0 keeps autoclear off, so a falling request must not clear
        for (int mode = 0; mode < 2; mode++) begin
            wr_reg(AUTOCLEAR_CTL_OFS, mode ? 32'h0 : 32'h0010_0000);
            for (int k = 0; k < 4; k++) begin
                s = k ? 5'($random(seed)) : 5'h1f;
                m = k ? 5'($random(seed)) : 5'h15;
                r = k ? 5'($random(seed)) : 5'h0a;
                @(posedge clk);
                pend_set <= s;
                @(posedge clk);
                pend_set <= 5'h00;
                settle();
                chk({27'h0, pend_bits}, {27'h0, s});
                wr_reg(PEND_CLEAR_OFS, {27'h7ff_ffff, m});
                settle();
                chk({27'h0, pend_bits}, {27'h0, exp_pend(s, m)});
                @(posedge clk);
                msg_req <= r;
                @(posedge clk);
                msg_req <= 5'h00;
                settle();
                v = {27'h0, exp_pend(exp_pend(s, m), mode ? r : 5'h00)};
                chk({27'h0, pend_bits}, v);
                wr_reg(PEND_CLEAR_OFS, 32'h0000_001f);
            end
        end
        $display("Test pending clear done");
        close_out();
    end
endmodule // tb_top
